// file: bcfg_host_model.sv
// configuration host model that issues accesses on the primary side
`timescale 1ns/1ps
module bcfg_host_model
   import bcfg_pkg::*;
(
   input wire logic clk,
   output logic cfg_req,
   output logic cfg_write,
   output logic [7:0] cfg_addr,
   output logic [3:0] cfg_byte_en,
   output logic [31:0] cfg_wdata,
   input wire logic cfg_ack,
   input wire logic [31:0] cfg_rdata
);
   initial
   begin
      cfg_req = 1'b0;
      cfg_write = 1'b0;
      cfg_addr = 8'h00;
      cfg_byte_en = 4'h0;
      cfg_wdata = 32'h0;
   end
   // one access: request pulse, then answer expected one cycle later
   // released lines show the inverse so stale values never look valid
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                       output logic [31:0] q, output logic ok);
      @(negedge clk);
      cfg_req = 1'b1;
      cfg_write = wr;
      cfg_addr = a;
      cfg_byte_en = be;
      cfg_wdata = d;
      @(negedge clk);
      cfg_req = 1'b0;
      cfg_write = ~wr;
      cfg_addr = ~a;
      cfg_byte_en = ~be;
      cfg_wdata = ~d;
      ok = cfg_ack;
      q = cfg_rdata;
   endtask
endmodule

// file: bcfg_palette_dec.sv
// palette snoop address decoder for primary i/o writes
`timescale 1ns/1ps
module bcfg_palette_dec
   import bcfg_pkg::*;
(
   input wire logic [15:0] io_addr,
   input wire logic io_write,
   input wire logic snoop_en,
   output logic hit
);
   logic [9:0] low_addr;

   // upper bits 15:10 are aliases and are not looked at
   assign low_addr = io_addr[9:0];

   // only writes are claimed; reads of the palette go to the normal decode
   assign hit = snoop_en && io_write &&
                ((low_addr == BCFG_PAL_MASK_ADDR) || (low_addr == BCFG_PAL_WRITE_ADDR) ||
                 (low_addr == BCFG_PAL_DATA_ADDR));
endmodule

// file: bcfg_pkg.sv
// constants for the bridge identity and command configuration registers
package bcfg_pkg;
   // configuration byte addresses of the two doublewords
   localparam logic [7:0] BCFG_OFF_IDENT = 8'h00;
   localparam logic [7:0] BCFG_OFF_CMD = 8'h04;
   // field positions inside the identity doubleword
   localparam int BCFG_MAKER_LSB = 0;
   localparam int BCFG_PART_LSB = 16;
   // command bit positions
   localparam int BCFG_CMD_IO_EN = 0;
   localparam int BCFG_CMD_MEM_EN = 1;
   localparam int BCFG_CMD_MASTER_EN = 2;
   localparam int BCFG_CMD_SPECIAL = 3;
   localparam int BCFG_CMD_MWI_EN = 4;
   localparam int BCFG_CMD_PALETTE_EN = 5;
   localparam int BCFG_CMD_PARITY_RESP = 6;
   localparam int BCFG_CMD_STEPPING = 7;
   localparam int BCFG_CMD_SERR_EN = 8;
   localparam int BCFG_CMD_FB2B_EN = 9;
   // status flag position in the command doubleword
   localparam int BCFG_STAT_DPERR = 24;
   // writable command bits: 0,1,2,5,6,8,9; bits 15:10 stay zero
   localparam logic [15:0] BCFG_CMD_RW_MASK = 16'h0367;
   localparam logic [15:0] BCFG_CMD_RESET = 16'h0000;
   localparam logic BCFG_DPERR_RESET = 1'h0;
   // palette addresses, low ten bits only
   localparam logic [9:0] BCFG_PAL_MASK_ADDR = 10'h3c6;
   localparam logic [9:0] BCFG_PAL_WRITE_ADDR = 10'h3c8;
   localparam logic [9:0] BCFG_PAL_DATA_ADDR = 10'h3c9;
endpackage

// file: bcfg_regs.sv
// identity and command configuration registers of the bridge primary port
`timescale 1ns/1ps
module bcfg_regs
   import bcfg_pkg::*;
#(
   parameter logic [15:0] MAKER_CODE = 16'h0a5c, // arbitrary value
   parameter logic [15:0] PART_CODE = 16'h0b6d // arbitrary value
)
(
   input wire logic clk,
   input wire logic rstn,
   // configuration access from the primary host
   input wire logic cfg_req,
   input wire logic cfg_write,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_byte_en,
   input wire logic [31:0] cfg_wdata,
   output logic cfg_ack,
   output logic [31:0] cfg_rdata,
   // primary target decode
   input wire logic p_io_req,
   input wire logic p_io_write,
   input wire logic [15:0] p_io_addr,
   input wire logic p_mem_req,
   output logic p_io_claim,
   output logic p_mem_claim,
   output logic p_palette_claim,
   // upstream forwarding
   input wire logic s_fwd_req,
   output logic s_fwd_claim,
   output logic p_master_en,
   input wire logic fwd_mwi_active,
   output logic p_fb2b_en,
   // parity and system error
   input wire logic primary_parity_error_sig_n,
   output logic parity_action,
   input wire logic serr_req,
   output logic primary_system_error_out_o,
   output logic primary_system_error_out_oe
);
   logic [15:0] cmd_ff;
   logic [15:0] nxt_cmd;
   logic [15:0] cmd_wmask;
   logic [15:0] cmd_view;
   logic dperr_ff;
   logic nxt_dperr;
   logic cfg_ack_ff;
   logic [31:0] cfg_rdata_ff;
   logic [31:0] nxt_rdata;
   logic wr_cmd;
   logic rd_hit_ident;
   logic rd_hit_cmd;
   logic perr_seen;
   logic dperr_clr;

   ////////////////////////////////////////////////////////////////////////////////
   // address decode of the configuration access
   assign rd_hit_ident = (cfg_addr[7:2] == BCFG_OFF_IDENT[7:2]);
   assign rd_hit_cmd = (cfg_addr[7:2] == BCFG_OFF_CMD[7:2]);
   assign wr_cmd = cfg_req && cfg_write && rd_hit_cmd;

   // only writable bits in enabled byte lanes can change
   assign cmd_wmask = BCFG_CMD_RW_MASK & {{8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}};

   // next command value; read-only and reserved bits never get stored
   always_comb
   begin
      nxt_cmd = cmd_ff;
      if (wr_cmd)
      begin
         nxt_cmd = (cmd_ff & ~cmd_wmask) | (cfg_wdata[15:0] & cmd_wmask);
      end
   end

   // command register storage
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cmd_ff <= BCFG_CMD_RESET;
      end
      else
      begin
         cmd_ff <= nxt_cmd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // data parity detected flag; a new error in the clearing cycle wins
   assign perr_seen = !primary_parity_error_sig_n && cmd_ff[BCFG_CMD_PARITY_RESP];
   assign dperr_clr = wr_cmd && cfg_byte_en[3] && cfg_wdata[BCFG_STAT_DPERR];

   always_comb
   begin
      nxt_dperr = dperr_ff;
      if (perr_seen)
      begin
         nxt_dperr = 1'h1;
      end
      else if (dperr_clr)
      begin
         nxt_dperr = 1'h0;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         dperr_ff <= BCFG_DPERR_RESET;
      end
      else
      begin
         dperr_ff <= nxt_dperr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read view of the command word: bit 4 mirrors an active forwarded invalidate
   always_comb
   begin
      cmd_view = cmd_ff & BCFG_CMD_RW_MASK;
      cmd_view[BCFG_CMD_MWI_EN] = fwd_mwi_active;
   end

   // read mux; unmapped doublewords read zero
   always_comb
   begin
      nxt_rdata = 32'h0000_0000;
      if (rd_hit_ident)
      begin
         nxt_rdata = {PART_CODE, MAKER_CODE};
      end
      else if (rd_hit_cmd)
      begin
         nxt_rdata = {7'h00, dperr_ff, 8'h00, cmd_view};
      end
   end

   // answer one cycle after the request, read or write alike
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cfg_ack_ff <= 1'h0;
         cfg_rdata_ff <= 32'h0000_0000;
      end
      else
      begin
         cfg_ack_ff <= cfg_req;
         if (cfg_req && !cfg_write)
         begin
            cfg_rdata_ff <= nxt_rdata;
         end
      end
   end

   assign cfg_ack = cfg_ack_ff;
   assign cfg_rdata = cfg_rdata_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // target and master gating driven straight from the command bits
   assign p_io_claim = p_io_req && cmd_ff[BCFG_CMD_IO_EN];
   assign p_mem_claim = p_mem_req && cmd_ff[BCFG_CMD_MEM_EN];
   assign p_master_en = cmd_ff[BCFG_CMD_MASTER_EN];
   assign s_fwd_claim = s_fwd_req && cmd_ff[BCFG_CMD_MASTER_EN];
   assign p_fb2b_en = cmd_ff[BCFG_CMD_FB2B_EN];
   assign parity_action = perr_seen;

   // open-drain error pin: drive low only while enabled
   assign primary_system_error_out_o = 1'h0;
   assign primary_system_error_out_oe = serr_req && cmd_ff[BCFG_CMD_SERR_EN];

   // palette decode kept apart so the alias rule stays in one place
   bcfg_palette_dec u_pal
   (
      .io_addr(p_io_addr),
      .io_write(p_io_write && p_io_req),
      .snoop_en(cmd_ff[BCFG_CMD_PALETTE_EN]),
      .hit(p_palette_claim)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   a_ident_read: assert property (@(posedge clk) disable iff (!rstn)
      (cfg_req && !cfg_write && rd_hit_ident) |=> (cfg_ack && cfg_rdata == {PART_CODE, MAKER_CODE}))
      else $error("identity doubleword read wrong");
   a_part_fixed: assert property (@(posedge clk) disable iff (!rstn)
      (cfg_ack && $past(rd_hit_ident && !cfg_write)) |-> (cfg_rdata[31:16] == PART_CODE))
      else $error("part code not fixed");
   a_cmd_write: assert property (@(posedge clk) disable iff (!rstn)
      (wr_cmd && cfg_byte_en[0]) |=> (cmd_ff[2:0] == $past(cfg_wdata[2:0])))
      else $error("command low bits not written");
   a_mem_gate: assert property (@(posedge clk) disable iff (!rstn)
      (wr_cmd && cfg_byte_en[0] && !cfg_wdata[1]) ##1 (p_mem_req && !wr_cmd) |-> !p_mem_claim)
      else $error("memory claimed while disabled");
   a_master_gate: assert property (@(posedge clk) disable iff (!rstn)
      s_fwd_claim |-> (p_master_en && s_fwd_req))
      else $error("forward claimed without master enable");
   a_ro_bits: assert property (@(posedge clk) disable iff (!rstn)
      (cfg_ack && $past(rd_hit_cmd && !cfg_write)) |-> (cfg_rdata[15:10] == 6'h00 && !cfg_rdata[3] && !cfg_rdata[7]))
      else $error("read-only command bits not zero");
   a_mwi_view: assert property (@(posedge clk) disable iff (!rstn)
      (cfg_req && !cfg_write && rd_hit_cmd) |=> (cfg_rdata[BCFG_CMD_MWI_EN] == $past(fwd_mwi_active)))
      else $error("invalidate enable view wrong");
   a_palette_dec: assert property (@(posedge clk) disable iff (!rstn)
      (p_io_req && p_io_write && cmd_ff[BCFG_CMD_PALETTE_EN] && p_io_addr[9:0] == 10'h3c8) |-> p_palette_claim)
      else $error("palette write not claimed");
   a_parity_flag: assert property (@(posedge clk) disable iff (!rstn)
      (!primary_parity_error_sig_n && cmd_ff[BCFG_CMD_PARITY_RESP]) |=> dperr_ff)
      else $error("parity flag not set");
   a_flag_clear: assert property (@(posedge clk) disable iff (!rstn)
      (dperr_clr && !perr_seen) |=> !dperr_ff)
      else $error("parity flag not cleared");
   a_serr_drv: assert property (@(posedge clk) disable iff (!rstn)
      (!cmd_ff[BCFG_CMD_SERR_EN] && !wr_cmd) |=> !primary_system_error_out_oe)
      else $error("error pin driven while disabled");
   a_ro_keep: assert property (@(posedge clk) disable iff (!rstn)
      wr_cmd |=> (cmd_ff[15:10] == 6'h00 && !cmd_ff[7] && !cmd_ff[4] && !cmd_ff[3]))
      else $error("read-only command bit stored");
   a_fb2b_en: assert property (@(posedge clk) disable iff (!rstn)
      (wr_cmd && cfg_byte_en[1]) |=> (p_fb2b_en == $past(cfg_wdata[9])))
      else $error("fast back-to-back enable not written");

   ////////////////////////////////////////////////////////////////////////////////
   // maker code on identity reads, then level checks on gates and stored bits that hold in every cycle, not only after a write
   a_maker_fixed: assert property (@(posedge clk) disable iff (!rstn)
      (cfg_ack && $past(rd_hit_ident && !cfg_write)) |-> (cfg_rdata[15:0] == MAKER_CODE))
      else $error("maker code not fixed");
   a_io_gate: assert property (@(posedge clk) disable iff (!rstn)
      !cmd_ff[BCFG_CMD_IO_EN] |-> !p_io_claim)
      else $error("i/o claimed while disabled");
   a_mem_level: assert property (@(posedge clk) disable iff (!rstn)
      !cmd_ff[BCFG_CMD_MEM_EN] |-> !p_mem_claim)
      else $error("memory claimed while bit clear");
   a_master_off: assert property (@(posedge clk) disable iff (!rstn)
      !cmd_ff[BCFG_CMD_MASTER_EN] |-> (!p_master_en && !s_fwd_claim))
      else $error("master active while disabled");
   a_special_ro: assert property (@(posedge clk) disable iff (!rstn)
      !cmd_ff[BCFG_CMD_SPECIAL])
      else $error("special cycle bit stored");
   a_mwi_store: assert property (@(posedge clk) disable iff (!rstn)
      !cmd_ff[BCFG_CMD_MWI_EN])
      else $error("invalidate enable bit stored");
   a_palette_off: assert property (@(posedge clk) disable iff (!rstn)
      !cmd_ff[BCFG_CMD_PALETTE_EN] |-> !p_palette_claim)
      else $error("palette claimed while snoop off");
   a_palette_rd: assert property (@(posedge clk) disable iff (!rstn)
      (p_io_req && !p_io_write) |-> !p_palette_claim)
      else $error("palette read claimed");
   a_parity_off: assert property (@(posedge clk) disable iff (!rstn)
      !cmd_ff[BCFG_CMD_PARITY_RESP] |-> !parity_action)
      else $error("parity action while response off");
   a_parity_on: assert property (@(posedge clk) disable iff (!rstn)
      (!primary_parity_error_sig_n && cmd_ff[BCFG_CMD_PARITY_RESP]) |-> parity_action)
      else $error("parity action missing");
   a_stepping_ro: assert property (@(posedge clk) disable iff (!rstn)
      !cmd_ff[BCFG_CMD_STEPPING])
      else $error("stepping bit stored");
   a_serr_on: assert property (@(posedge clk) disable iff (!rstn)
      (serr_req && cmd_ff[BCFG_CMD_SERR_EN]) |-> primary_system_error_out_oe)
      else $error("error pin not driven while enabled");
   a_fb2b_off: assert property (@(posedge clk) disable iff (!rstn)
      !cmd_ff[BCFG_CMD_FB2B_EN] |-> !p_fb2b_en)
      else $error("fast back-to-back on while bit clear");
   a_reserved_ro: assert property (@(posedge clk) disable iff (!rstn)
      (cmd_ff[15:10] == 6'h00))
      else $error("reserved command bits stored");

   ////////////////////////////////////////////////////////////////////////////////
   // flag ordering: a new error beats a clear landing in the same cycle
   a_flag_wins: assert property (@(posedge clk) disable iff (!rstn)
      (perr_seen && dperr_clr) |=> dperr_ff)
      else $error("clear beat a new parity error");
   a_flag_hold: assert property (@(posedge clk) disable iff (!rstn)
      (!perr_seen && !dperr_clr) |=> (dperr_ff == $past(dperr_ff)))
      else $error("parity flag changed by itself");

   ////////////////////////////////////////////////////////////////////////////////
   // bus answer: exactly one acknowledge per request, and ident writes touch nothing
   a_ack_pulse: assert property (@(posedge clk) disable iff (!rstn)
      cfg_req |=> cfg_ack)
      else $error("request not acknowledged");
   a_ack_quiet: assert property (@(posedge clk) disable iff (!rstn)
      !cfg_req |=> !cfg_ack)
      else $error("acknowledge without request");
   a_ident_keep: assert property (@(posedge clk) disable iff (!rstn)
      (cfg_req && cfg_write && rd_hit_ident) |=> (cmd_ff == $past(cmd_ff)))
      else $error("identity write changed command");
endmodule

// file: bcfg_regs_tb.sv
// self-checking bench for the identity and command registers
`timescale 1ns/1ps
module bcfg_regs_tb;
   import bcfg_pkg::*;
   localparam logic [15:0] MK = 16'h1357; // arbitrary value
   localparam logic [15:0] PT = 16'h2468; // arbitrary value
   logic clk = 1'b0, rstn = 1'b0, cfg_req, cfg_write, cfg_ack, p_io_req = 1'b0, p_io_write = 1'b0;
   logic p_mem_req = 1'b0, s_fwd_req = 1'b0, fwd_mwi_active = 1'b0, perr_n = 1'b1, serr_req = 1'b0;
   logic p_io_claim, p_mem_claim, p_palette_claim, s_fwd_claim, p_master_en, p_fb2b_en, parity_action, so, soe;
   logic [7:0] cfg_addr;
   logic [3:0] cfg_byte_en;
   logic [31:0] cfg_wdata, cfg_rdata, q;
   logic [15:0] p_io_addr = 16'h0;
   logic [9:0] pal [4] = '{10'h3c6, 10'h3c8, 10'h3c9, 10'h3c7};
   int bad_count = 0, checks = 0, cyc = 0;
   bcfg_regs #(.MAKER_CODE(MK), .PART_CODE(PT)) i_bcfg_regs (.clk(clk), .rstn(rstn), .cfg_req(cfg_req),
      .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
      .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .p_io_req(p_io_req), .p_io_write(p_io_write),
      .p_io_addr(p_io_addr), .p_mem_req(p_mem_req), .p_io_claim(p_io_claim), .p_mem_claim(p_mem_claim),
      .p_palette_claim(p_palette_claim), .s_fwd_req(s_fwd_req), .s_fwd_claim(s_fwd_claim),
      .p_master_en(p_master_en), .fwd_mwi_active(fwd_mwi_active), .p_fb2b_en(p_fb2b_en),
      .primary_parity_error_sig_n(perr_n), .parity_action(parity_action), .serr_req(serr_req),
      .primary_system_error_out_o(so), .primary_system_error_out_oe(soe));
   bcfg_host_model i_bcfg_host_model (.clk(clk), .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
      .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));
   always #5 clk = ~clk;
   // watchdog: the whole run needs about thirty cycles
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         bad_count = bad_count + 1;
         end_sim();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks = checks + 1;
      if (g !== e)
      begin
         bad_count = bad_count + 1;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // every access must be answered one cycle after it is taken
   task automatic acc(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      logic ok;
      i_bcfg_host_model.xfer(wr, a, be, d, q, ok);
      chk("ack", 32'h1, {31'h0, ok});
   endtask
   task automatic outs(input logic [7:0] e);
      chk("gates", {24'h0, e}, {24'h0, p_io_claim, p_mem_claim, s_fwd_claim, soe, parity_action, p_master_en,
         p_fb2b_en, so});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // identity fields after reset and after an attempted overwrite
   task automatic t_ident();
      acc(1'b0, BCFG_OFF_IDENT, 4'hf, 32'h0);
      chk("ident", {PT, MK}, q);
      acc(1'b1, BCFG_OFF_IDENT, 4'hf, 32'hffff_ffff);
      acc(1'b0, BCFG_OFF_IDENT, 4'h0, 32'h0);
      chk("ident_wr", {PT, MK}, q);
      acc(1'b0, BCFG_OFF_CMD, 4'hf, 32'h0);
      chk("cmd_rst", 32'h0, q);
   endtask
   // all ones written: read-only bits stay zero, every gate but the palette claim opens
   task automatic t_cmd();
      {p_io_req, p_mem_req, s_fwd_req, serr_req} = 4'hf;
      outs(8'h00);
      acc(1'b1, BCFG_OFF_CMD, 4'h3, 32'h0000_ffff);
      acc(1'b0, BCFG_OFF_CMD, 4'hf, 32'h0);
      chk("cmd_ro", 32'h0000_0367, q);
      perr_n = 1'b0;
      #1 outs(8'hfe);
      // the error must span a rising edge to reach the flag
      @(negedge clk);
      perr_n = 1'b1;
      fwd_mwi_active = 1'b1;
      acc(1'b0, BCFG_OFF_CMD, 4'hf, 32'h0);
      chk("cmd_mwi", 32'h0100_0377, q);
      fwd_mwi_active = 1'b0;
      acc(1'b1, BCFG_OFF_CMD, 4'h3, 32'h0);
      outs(8'h00);
      {p_io_req, p_mem_req, s_fwd_req, serr_req} = 4'h0;
   endtask
   // palette writes claimed on low ten bits with high bits set, reads never
   task automatic t_palette();
      acc(1'b1, BCFG_OFF_CMD, 4'h1, 32'h20);
      p_io_req = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         p_io_addr = {6'h3f, pal[i]};
         p_io_write = 1'b1;
         #1 chk("pal_wr", {31'h0, i < 3}, {31'h0, p_palette_claim});
         p_io_write = 1'b0;
         #1 chk("pal_rd", 32'h0, {31'h0, p_palette_claim});
      end
      // a real palette address, so only the cleared bit can block the claim
      p_io_addr = {6'h3f, pal[1]};
      p_io_write = 1'b1;
      acc(1'b1, BCFG_OFF_CMD, 4'h1, 32'h0);
      chk("pal_off", 32'h0, {31'h0, p_palette_claim});
      p_io_req = 1'b0;
   endtask
   // parity flag: no set while response is off, write-one clears it
   task automatic t_parity();
      acc(1'b1, BCFG_OFF_CMD, 4'h8, 32'h0100_0000);
      acc(1'b0, BCFG_OFF_CMD, 4'hf, 32'h0);
      chk("flag_clr", 32'h0, q);
      perr_n = 1'b0;
      acc(1'b0, BCFG_OFF_CMD, 4'hf, 32'h0);
      chk("flag_off", 32'h0, q);
      perr_n = 1'b1;
   endtask
   initial
   begin
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      t_ident();
      t_cmd();
      t_palette();
      t_parity();
      end_sim();
   end
endmodule
